// File: verilog/prdc_top.sv
// top: axi4-lite registers, reload overrun flags, irq and dead-time correction select
`timescale 1ns/100ps
module prdc_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire prdc_pkg::prdc_axi_req_t axi_req_i,
    output prdc_pkg::prdc_axi_rsp_t axi_rsp_o,
    input wire logic [prdc_pkg::GEN_W-1:0] reload_i,
    input wire logic count_down_i,
    input wire logic [prdc_pkg::NUM_PAIRS-1:0] cur_status_input_n_i,
    output logic [prdc_pkg::NUM_PAIRS-1:0] use_even_o,
    output logic [prdc_pkg::GEN_W-1:0] overrun_flag_o,
    output logic irq_o
);
    import prdc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        prdc_axi_rsp_t rsp;
        logic aw_got;
        logic w_got;
        logic [AXI_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [GEN_W-1:0] irq_en;
        logic [GEN_W-1:0] permit;
        logic global_permit;
        logic [1:0] src_sel;
        logic [NUM_PAIRS-1:0] corr_pol;
        logic [CC_MODE_W-1:0] corr_mode;
        logic [GEN_W-1:0] flag_clr;
        logic irq;
        logic [NUM_PAIRS-1:0] cs_meta;
        logic [NUM_PAIRS-1:0] cs_sync;
    } prdc_top_state_t;

    prdc_top_state_t s_q, s_d;
    logic [GEN_W-1:0] flags;
    logic [NUM_PAIRS-1:0] use_even;
    prdc_ctrl_t ctrl;

    // pick the byte lane that holds a given register address
    function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [AXI_AW-1:0] a);
        logic [1:0] l;
        l = a[1:0];
        case (l)
            2'h0: lane_byte = w[7:0];
            2'h1: lane_byte = w[15:8];
            2'h2: lane_byte = w[23:16];
            default: lane_byte = w[31:24];
        endcase
    endfunction

    function automatic logic lane_on(input logic [3:0] s, input logic [AXI_AW-1:0] a);
        lane_on = s[a[1:0]];
    endfunction

    // place a byte in its lane of the read word
    function automatic logic [31:0] lane_word(input logic [7:0] b, input logic [AXI_AW-1:0] a);
        logic [31:0] w;
        w = {24'h00_0000, b};
        lane_word = w << {a[1:0], 3'h0};
    endfunction

    assign ctrl.permit = s_q.permit;
    assign ctrl.global_permit = s_q.global_permit;
    assign ctrl.src_sel = s_q.src_sel;
    assign ctrl.corr_pol = s_q.corr_pol;
    assign ctrl.corr_mode = s_q.corr_mode;
    assign ctrl.irq_en = s_q.irq_en;
    assign ctrl.flag_clr = s_q.flag_clr;

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    prdc_overrun u_overrun (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .reload_i(reload_i),
        .permit_i(ctrl.permit),
        .global_permit_i(ctrl.global_permit),
        .src_sel_i(ctrl.src_sel),
        .clr_i(ctrl.flag_clr),
        .flag_o(flags)
    );

    prdc_corr_sel u_corr (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .cur_status_sync_n_i(s_q.cs_sync),
        .corr_pol_i(ctrl.corr_pol),
        .corr_mode_i(ctrl.corr_mode),
        .count_down_i(count_down_i),
        .use_even_o(use_even)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [AXI_AW-1:0] ra;
        logic [7:0] rb;
        logic [7:0] wb;
        logic hit;
        ra = '0;
        rb = RESET_BYTE;
        wb = RESET_BYTE;
        hit = 1'b0;
        s_d = s_q;
        s_d.flag_clr = '0;
        // status pin enters through two flops; only the second is used
        s_d.cs_meta = cur_status_input_n_i;
        s_d.cs_sync = s_q.cs_meta;

        // write address and data are taken in either order
        if (axi_req_i.awvalid && s_q.rsp.awready) begin
            s_d.awaddr = axi_req_i.awaddr;
            s_d.aw_got = 1'b1;
            s_d.rsp.awready = 1'b0;
        end
        if (axi_req_i.wvalid && s_q.rsp.wready) begin
            s_d.wdata = axi_req_i.wdata;
            s_d.wstrb = axi_req_i.wstrb;
            s_d.w_got = 1'b1;
            s_d.rsp.wready = 1'b0;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid) begin
            wb = lane_byte(s_q.wdata, s_q.awaddr);
            hit = 1'b1;
            if (lane_on(s_q.wstrb, s_q.awaddr)) begin
                case (s_q.awaddr)
                    ADDR_IRQ_EN: s_d.irq_en = wb[GEN_W-1:0];
                    ADDR_FLAGS: s_d.flag_clr = wb[GEN_W-1:0];
                    ADDR_CORR_CTRL: begin
                        s_d.corr_pol = wb[CC_POL_LSB +: NUM_PAIRS];
                        s_d.corr_mode = wb[CC_MODE_LSB +: CC_MODE_W];
                    end
                    ADDR_LOAD_CTRL: begin
                        s_d.permit = wb[LC_PERMIT_LSB +: GEN_W];
                        s_d.global_permit = wb[LC_GLOBAL_BIT];
                        s_d.src_sel = wb[LC_SRC_LSB +: 2];
                    end
                    ADDR_PAIR_SEL: hit = 1'b1;
                    default: hit = 1'b0;
                endcase
            end else begin
                case (s_q.awaddr)
                    ADDR_IRQ_EN, ADDR_FLAGS, ADDR_CORR_CTRL,
                    ADDR_LOAD_CTRL, ADDR_PAIR_SEL: hit = 1'b1;
                    default: hit = 1'b0;
                endcase
            end
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_q.rsp.bvalid && axi_req_i.bready) begin
            s_d.rsp.bvalid = 1'b0;
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.rsp.awready = 1'b1;
            s_d.rsp.wready = 1'b1;
        end

        // read channel
        if (axi_req_i.arvalid && s_q.rsp.arready) begin
            ra = axi_req_i.araddr;
            hit = 1'b1;
            case (ra)
                ADDR_IRQ_EN: rb = {5'h00, s_q.irq_en};
                ADDR_FLAGS: rb = {5'h00, flags};
                ADDR_CORR_CTRL: rb = {2'h0, s_q.corr_mode, 1'b0, s_q.corr_pol};
                ADDR_LOAD_CTRL: rb = {2'h0, s_q.src_sel, s_q.global_permit, s_q.permit};
                ADDR_PAIR_SEL: rb = {5'h00, use_even};
                default: hit = 1'b0;
            endcase
            s_d.rsp.arready = 1'b0;
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata = hit ? lane_word(rb, ra) : ZERO_WORD;
            s_d.rsp.rresp = hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_q.rsp.rvalid && axi_req_i.rready) begin
            s_d.rsp.rvalid = 1'b0;
            s_d.rsp.arready = 1'b1;
        end

        s_d.irq = |(flags & s_q.irq_en);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.rsp.awready <= 1'b1;
            s_q.rsp.wready <= 1'b1;
            s_q.rsp.arready <= 1'b1;
            s_q.cs_meta <= '1;
            s_q.cs_sync <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign axi_rsp_o = s_q.rsp;
    assign use_even_o = use_even;
    assign overrun_flag_o = flags;
    assign irq_o = s_q.irq;
endmodule

// File: common/prdc_pkg.sv
// package: register map, field layout and carrier types for the overrun / correction block
package prdc_pkg;

    localparam int unsigned NUM_PAIRS = 3;
    localparam int unsigned AXI_AW = 8;

    // register indices; each register owns one aligned 32-bit word
    localparam logic [AXI_AW-1:0] IDX_IRQ_EN = 8'h1C;
    localparam logic [AXI_AW-1:0] IDX_FLAGS = 8'h1D;
    localparam logic [AXI_AW-1:0] IDX_CORR_CTRL = 8'h1E;
    localparam logic [AXI_AW-1:0] IDX_LOAD_CTRL = 8'h1F;
    localparam logic [AXI_AW-1:0] IDX_PAIR_SEL = 8'h20;
    localparam logic [1:0] ADDR_ALIGN = 2'h0;

    // byte address is four times the index; the value sits in bits 7:0
    localparam logic [AXI_AW-1:0] ADDR_IRQ_EN = {IDX_IRQ_EN[AXI_AW-3:0], ADDR_ALIGN};
    localparam logic [AXI_AW-1:0] ADDR_FLAGS = {IDX_FLAGS[AXI_AW-3:0], ADDR_ALIGN};
    localparam logic [AXI_AW-1:0] ADDR_CORR_CTRL = {IDX_CORR_CTRL[AXI_AW-3:0], ADDR_ALIGN};
    localparam logic [AXI_AW-1:0] ADDR_LOAD_CTRL = {IDX_LOAD_CTRL[AXI_AW-3:0], ADDR_ALIGN};
    localparam logic [AXI_AW-1:0] ADDR_PAIR_SEL = {IDX_PAIR_SEL[AXI_AW-3:0], ADDR_ALIGN};

    // flag and enable bit positions
    localparam int unsigned BIT_A = 0;
    localparam int unsigned BIT_B = 1;
    localparam int unsigned BIT_C = 2;
    localparam int unsigned GEN_W = 3;

    // reload source select encodings
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_A = 2'h1;
    localparam logic [1:0] SRC_B = 2'h2;
    localparam logic [1:0] SRC_C = 2'h3;

    // correction control register layout
    localparam int unsigned CC_POL_LSB = 0;
    localparam int unsigned CC_MODE_LSB = 4;
    localparam int unsigned CC_MODE_W = 2;
    localparam logic [CC_MODE_W-1:0] CC_MODE_SW = 2'h0;
    localparam logic [CC_MODE_W-1:0] CC_MODE_DIR = 2'h3;

    // load control register layout
    localparam int unsigned LC_PERMIT_LSB = 0;
    localparam int unsigned LC_GLOBAL_BIT = 3;
    localparam int unsigned LC_SRC_LSB = 4;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [AXI_AW-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [AXI_AW-1:0] araddr;
        logic arvalid;
        logic rready;
    } prdc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } prdc_axi_rsp_t;

    // software view handed from the bus slave to the block logic
    typedef struct packed {
        logic [GEN_W-1:0] permit;
        logic global_permit;
        logic [1:0] src_sel;
        logic [NUM_PAIRS-1:0] corr_pol;
        logic [CC_MODE_W-1:0] corr_mode;
        logic [GEN_W-1:0] irq_en;
        logic [GEN_W-1:0] flag_clr;
    } prdc_ctrl_t;

endpackage

// File: verilog/prdc_overrun.sv
// overrun flag logic for the three reload generators
`timescale 1ns/100ps
module prdc_overrun (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [prdc_pkg::GEN_W-1:0] reload_i,
    input wire logic [prdc_pkg::GEN_W-1:0] permit_i,
    input wire logic global_permit_i,
    input wire logic [1:0] src_sel_i,
    input wire logic [prdc_pkg::GEN_W-1:0] clr_i,
    output logic [prdc_pkg::GEN_W-1:0] flag_o
);
    import prdc_pkg::*;

    typedef struct packed {
        logic [GEN_W-1:0] flag;
    } prdc_ovr_state_t;

    prdc_ovr_state_t s_q, s_d;
    logic [GEN_W-1:0] set;

    // reload seen while no load permit covers it
    function automatic logic overrun_hit(input logic ev, input logic perm, input logic glob);
        overrun_hit = ev & ~(perm | glob);
    endfunction

    always_comb begin
        set = '0;
        set[BIT_B] = overrun_hit(reload_i[BIT_B], permit_i[BIT_B], global_permit_i);
        set[BIT_C] = overrun_hit(reload_i[BIT_C], permit_i[BIT_C], global_permit_i);
        case (src_sel_i)
            SRC_A: set[BIT_A] = overrun_hit(reload_i[BIT_A], permit_i[BIT_A], global_permit_i);
            SRC_B: set[BIT_A] = overrun_hit(reload_i[BIT_A], permit_i[BIT_B], global_permit_i);
            SRC_C: set[BIT_A] = overrun_hit(reload_i[BIT_A], permit_i[BIT_C], global_permit_i);
            default: set[BIT_A] = 1'b0;
        endcase
        s_d.flag = (s_q.flag & ~clr_i) | set;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag_o = s_q.flag;
endmodule

// File: verilog/prdc_corr_sel.sv
// odd/even value register selection for each complementary pair
`timescale 1ns/100ps
module prdc_corr_sel (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [prdc_pkg::NUM_PAIRS-1:0] cur_status_sync_n_i,
    input wire logic [prdc_pkg::NUM_PAIRS-1:0] corr_pol_i,
    input wire logic [prdc_pkg::CC_MODE_W-1:0] corr_mode_i,
    input wire logic count_down_i,
    output logic [prdc_pkg::NUM_PAIRS-1:0] use_even_o
);
    import prdc_pkg::*;

    typedef struct packed {
        logic [NUM_PAIRS-1:0] use_even;
    } prdc_sel_state_t;

    prdc_sel_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        case (corr_mode_i)
            CC_MODE_SW: s_d.use_even = corr_pol_i;
            CC_MODE_DIR: s_d.use_even = {NUM_PAIRS{count_down_i}};
            default: s_d.use_even = cur_status_sync_n_i;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign use_even_o = s_q.use_even;
endmodule

// File: tb/prdc_top_monitor.sv
// checker on the top ports of the overrun / correction block
`timescale 1ns/100ps
module prdc_top_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire prdc_pkg::prdc_axi_req_t axi_req_i,
    input wire prdc_pkg::prdc_axi_rsp_t axi_rsp_o,
    input wire logic [prdc_pkg::GEN_W-1:0] reload_i,
    input wire logic [prdc_pkg::GEN_W-1:0] overrun_flag_o,
    input wire logic irq_o
);
    import prdc_pkg::*;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_wr;
        axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
    endsequence
    sequence s_rd;
        axi_req_i.arvalid && axi_rsp_o.arready;
    endsequence
    a_flag_c_set: assert property ($rose(overrun_flag_o[BIT_C]) |-> $past(reload_i[BIT_C]))
        else $error("flag c set without reload");
    a_flag_b_set: assert property ($rose(overrun_flag_o[BIT_B]) |-> $past(reload_i[BIT_B]))
        else $error("flag b set without reload");
    a_flag_a_set: assert property ($rose(overrun_flag_o[BIT_A]) |-> $past(reload_i[BIT_A]))
        else $error("flag a set without reload");
    a_flag_w1c: assert property (
        |($past(overrun_flag_o) & ~overrun_flag_o) |-> $past(axi_rsp_o.bvalid))
        else $error("flag cleared without write");
    a_irq_cause: assert property (irq_o |-> $past(|overrun_flag_o))
        else $error("irq without flag");
    a_flag_read: assert property (
        s_rd ##0 (axi_req_i.araddr == ADDR_FLAGS)
        |=> axi_rsp_o.rdata[7:0] == {5'h00, $past(overrun_flag_o)})
        else $error("flag readback wrong");
    a_wr_answer: assert property (s_wr |-> ##[1:2] axi_rsp_o.bvalid)
        else $error("write answer late");
    a_rd_answer: assert property (s_rd |=> axi_rsp_o.rvalid && !axi_rsp_o.arready)
        else $error("read answer late");
endmodule

bind prdc_top prdc_top_monitor i_mon (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .axi_req_i(axi_req_i),
    .axi_rsp_o(axi_rsp_o),
    .reload_i(reload_i),
    .overrun_flag_o(overrun_flag_o),
    .irq_o(irq_o)
);

// File: tb/prdc_gate_model.sv
// gate driver stand-in: reports which transistor of each pair conducts
`timescale 1ns/100ps
module prdc_gate_model (
    input wire logic ref_clk_i,
    input wire logic [prdc_pkg::NUM_PAIRS-1:0] current_neg_i,
    output logic [prdc_pkg::NUM_PAIRS-1:0] cur_status_n_o
);
    import prdc_pkg::*;
    // sense comparator settles one clock after the current turns
    always_ff @(posedge ref_clk_i) begin
        cur_status_n_o <= current_neg_i;
    end
endmodule

// File: tb/testbench.sv
// bench for reload overrun flags, irq and odd/even register selection
`timescale 1ns/100ps
module testbench;
    import prdc_pkg::*;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, count_down_i = 1'b0, irq_o;
    logic [2:0] reload_i = 3'h0, cur_neg = 3'h0, status_n, use_even_o, overrun_flag_o;
    logic [7:0] rb;
    logic [1:0] resp;
    prdc_axi_req_t req = '0;
    prdc_axi_rsp_t rsp;
    int n_errors = 0, checks = 0, cycles = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    prdc_top i_dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .axi_req_i(req), .axi_rsp_o(rsp),
        .reload_i(reload_i), .count_down_i(count_down_i), .cur_status_input_n_i(status_n),
        .use_even_o(use_even_o), .overrun_flag_o(overrun_flag_o), .irq_o(irq_o)
    );
    prdc_gate_model i_gate (.ref_clk_i(ref_clk_i), .current_neg_i(cur_neg), .cur_status_n_o(status_n));

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, the sequence needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        resp = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic rd(input logic [7:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rb = 8'(rsp.rdata >> (8 * a[1:0]));
        resp = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    // byte registers sit in the lane given by the low address bits
    task automatic wb(input logic [7:0] a, input logic [7:0] v);
        wr(a, 32'(v) << (8 * a[1:0]), 4'h1 << a[1:0]);
    endtask

    task automatic pulse(input logic [2:0] m);
        reload_i <= m;
        @(posedge ref_clk_i);
        reload_i <= 3'h0;
        repeat (2) @(posedge ref_clk_i);
    endtask

    task automatic flags(input logic [2:0] e);
        rd(ADDR_FLAGS);
        chk(rb, {5'h00, e});
        chk(overrun_flag_o, e);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic t_overrun();
        for (int s = 0; s < 4; s++) begin
            wb(ADDR_LOAD_CTRL, 8'(s << LC_SRC_LSB) | 8'h01);
            pulse(3'h7);
            flags({2'b11, s > 1});
            wb(ADDR_FLAGS, 8'h07);
        end
        wb(ADDR_LOAD_CTRL, 8'h26);
        pulse(3'h7);
        flags(3'h0);
        wb(ADDR_LOAD_CTRL, 8'h38);
        pulse(3'h7);
        flags(3'h0);
        wb(ADDR_LOAD_CTRL, 8'h00);
        pulse(3'h4);
        flags(3'h4);
        pulse(3'h2);
        flags(3'h6);
        $display("overrun test done");
    endtask

    task automatic t_w1c();
        wb(ADDR_FLAGS, 8'h00);
        flags(3'h6);
        // ones in the register's byte but its strobe off: no effect
        wr(ADDR_FLAGS, 32'h0000_0007, 4'h2);
        flags(3'h6);
        wb(ADDR_FLAGS, 8'h02);
        chk(resp, RESP_OKAY);
        flags(3'h4);
        $display("clear test done");
    endtask

    task automatic t_irq();
        wb(ADDR_IRQ_EN, 8'h03);
        tick(2);
        chk(irq_o, 1'b0);
        rd(ADDR_IRQ_EN);
        chk(rb, 8'h03);
        wb(ADDR_IRQ_EN, 8'h04);
        tick(2);
        chk(irq_o, 1'b1);
        wb(ADDR_IRQ_EN, 8'h00);
        tick(2);
        chk(irq_o, 1'b0);
        wb(ADDR_IRQ_EN, 8'h07);
        wb(ADDR_FLAGS, 8'h04);
        tick(2);
        chk(irq_o, 1'b0);
        $display("irq test done");
    endtask

    task automatic t_corr();
        wb(ADDR_CORR_CTRL, 8'h05);
        tick(6);
        chk(use_even_o, 3'h5);
        wb(ADDR_CORR_CTRL, 8'h33);
        count_down_i <= 1'b1;
        tick(6);
        chk(use_even_o, 3'h7);
        count_down_i <= 1'b0;
        tick(6);
        chk(use_even_o, 3'h0);
        cur_neg <= 3'h2;
        wb(ADDR_CORR_CTRL, 8'h10);
        tick(6);
        chk(use_even_o, 3'h2);
        cur_neg <= 3'h5;
        wb(ADDR_CORR_CTRL, 8'h21);
        tick(6);
        chk(use_even_o, 3'h5);
        rd(ADDR_PAIR_SEL);
        chk(rb, 8'h05);
        $display("correction test done");
    endtask

    initial begin
        tick(16);
        rst_i <= 1'b0;
        tick(1);
        flags(3'h0);
        rd(ADDR_IRQ_EN);
        chk(rb, 8'h00);
        rd(8'h30);
        chk(resp, RESP_SLVERR);
        wb(8'h30, 8'h01);
        chk(resp, RESP_SLVERR);
        $display("reset test done");
        t_overrun();
        t_w1c();
        t_irq();
        t_corr();
        complete_run();
    end
endmodule
